/* File: src/arc_defs.svh */
// constants for the alarm reset edge clear block
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH
`define ARC_CFG_W 2
`define ARC_CFG_FALL 2'h1
`define ARC_CFG_RISE 2'h2
`define ARC_CFG_GPIO 2'h3
`define ARC_CFG_RST 2'h3
`define ARC_SYNC_STAGES 2
`endif

/* File: src/arc_pkg.sv */
// types for the alarm reset edge clear block
`include "arc_defs.svh"
package arc_pkg;
   typedef logic [`ARC_CFG_W-1:0] arc_cfg_t;
   typedef enum logic [2:0] {
      ARC_GPIO = 3'h1,
      ARC_FALL = 3'h2,
      ARC_RISE = 3'h4
   } arc_mode_e;
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } arc_sync_s;
   typedef struct packed {
      arc_mode_e mode;
      logic clr;
      logic gpio;
   } arc_core_s;
endpackage : arc_pkg

/* File: src/arc_sync.sv */
// two-stage synchroniser with edge detection on the settled side
`timescale 1ns/1ps
`default_nettype none
module arc_sync
   import arc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic en,
   input wire logic din,
   output logic dout,
   output logic rise,
   output logic fall
);
   arc_sync_s st_q;
   arc_sync_s st_d;

   // shift the pin through two stages, keep the settled value's history
   always_comb begin
      st_d = st_q;
      if (en) begin
         st_d.s1 = din;
         st_d.s2 = st_q.s1;
         st_d.prev = st_q.s2;
      end
   end

   // reset to high: an open input reads high, so no false edge at start
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= 3'h7;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.s2;
   assign rise = en & st_q.s2 & ~st_q.prev;
   assign fall = en & ~st_q.s2 & st_q.prev;
endmodule : arc_sync
`default_nettype wire

/* File: src/arc_alarm_reset.sv */
// alarm reset input watcher that pulses an alarm clear on a chosen edge
//
// What this block does
// - a qualifying edge on the reset input clears all warnings and faults.
// - configuration 1 clears only on a high-to-low transition of the input.
// - configuration 1 never clears while the input holds high.
// - configuration 1 ignores low-to-high transitions; the next fall clears.
// - configuration 2 clears only on a low-to-high transition of the input.
// - configuration 2 ignores falls and steady levels.
//
// timing: a pin change shows on alarm_clear three enabled edges later,
// two for the synchroniser and one for the output flop; the edge detect is combinational.
// pulses shorter than one cycle may be missed; that is the price of
// settling an asynchronous contact without a filter.
// the clear is a pulse only; the alarm store that it empties lives outside.
// a configuration change takes effect one enabled edge after it is seen, and
// edges already in the synchroniser are judged by the new mode.
// clk_en low freezes synchroniser, mode and outputs alike.
`timescale 1ns/1ps
`default_nettype none
module arc_alarm_reset
   import arc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic alarm_reset_input,
   input wire logic [`ARC_CFG_W-1:0] alarm_reset_config,
   output logic alarm_clear,
   output logic gpio_level
);
   arc_core_s st_q;
   arc_core_s st_d;
   logic pin_lvl;
   logic pin_rise;
   logic pin_fall;

   // map the configuration code onto a one-hot mode
   function automatic arc_mode_e decode_cfg(input arc_cfg_t cfg);
      case (cfg)
         `ARC_CFG_FALL: decode_cfg = ARC_FALL;
         `ARC_CFG_RISE: decode_cfg = ARC_RISE;
         default: decode_cfg = ARC_GPIO; // code 0 unused, treated as plain input
      endcase
   endfunction : decode_cfg

   // pick the edge that counts for the registered mode; other modes never clear
   function automatic logic edge_clears(input arc_mode_e mode, input logic rise, input logic fall);
      case (mode)
         ARC_FALL: edge_clears = fall;
         ARC_RISE: edge_clears = rise;
         ARC_GPIO: edge_clears = 1'b0;
         default: edge_clears = 1'b0;
      endcase
   endfunction : edge_clears

   // pin is asynchronous to our clock, settle it before use
   arc_sync u_sync (
      .clock(clock),
      .rst_b(rst_b),
      .en(clk_en),
      .din(alarm_reset_input),
      .dout(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // mode is sampled each cycle; clear is a one-cycle pulse
   always_comb begin
      st_d = st_q;
      if (clk_en) begin
         st_d.mode = decode_cfg(alarm_reset_config);
         st_d.gpio = pin_lvl;
         st_d.clr = edge_clears(st_q.mode, pin_rise, pin_fall);
      end
   end

   // default mode is general purpose so nothing clears before configuration
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '{mode: ARC_GPIO, clr: 1'b0, gpio: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   assign alarm_clear = st_q.clr;
   assign gpio_level = st_q.gpio;

   // helper: settled level one cycle back, held while clock enable is low
   logic lvl_q;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lvl_q <= 1'b1;
      end else if (clk_en) begin
         lvl_q <= pin_lvl;
      end
   end

   // sequences shared by the properties below
   sequence s_fall_seen;
      clk_en && st_q.mode == ARC_FALL && pin_fall;
   endsequence

   sequence s_rise_seen;
      clk_en && st_q.mode == ARC_RISE && pin_rise;
   endsequence

   sequence s_clear_pulse;
      alarm_clear ##1 !alarm_clear;
   endsequence

   // a settled fall in falling mode must give a pulse on the next edge
   property p_fall_clears;
      @(posedge clock) disable iff (!rst_b)
      s_fall_seen |=> alarm_clear;
   endproperty
   a_fall_clears: assert property (p_fall_clears) else $error("fall edge missed");

   // a new pulse in falling mode must come from a fall one edge back
   property p_fall_mode_only_fall;
      @(posedge clock) disable iff (!rst_b)
      ($rose(alarm_clear) && $past(st_q.mode) == ARC_FALL) |-> $past(pin_fall);
   endproperty
   a_fall_mode_only_fall: assert property (p_fall_mode_only_fall) else $error("bad fall clear");

   // steady high in falling mode never clears, however long it lasts
   property p_high_no_clear;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && st_q.mode == ARC_FALL && pin_lvl && lvl_q) |=> !alarm_clear;
   endproperty
   a_high_no_clear: assert property (p_high_no_clear) else $error("clear while high");

   // a rise in falling mode is ignored; only the next fall counts
   property p_fall_ignores_rise;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && st_q.mode == ARC_FALL && pin_rise) |=> !alarm_clear;
   endproperty
   a_fall_ignores_rise: assert property (p_fall_ignores_rise) else $error("clear on rise");

   // a settled rise in rising mode must give a pulse on the next edge
   property p_rise_clears;
      @(posedge clock) disable iff (!rst_b)
      s_rise_seen |=> alarm_clear;
   endproperty
   a_rise_clears: assert property (p_rise_clears) else $error("rise edge missed");

   // a new pulse in rising mode must come from a rise one edge back
   property p_rise_mode_only_rise;
      @(posedge clock) disable iff (!rst_b)
      ($rose(alarm_clear) && $past(st_q.mode) == ARC_RISE) |-> $past(pin_rise);
   endproperty
   a_rise_mode_only_rise: assert property (p_rise_mode_only_rise) else $error("bad rise clear");

   // falls and steady levels in rising mode give nothing
   property p_rise_no_fall;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && st_q.mode == ARC_RISE && !pin_rise) |=> !alarm_clear;
   endproperty
   a_rise_no_fall: assert property (p_rise_no_fall) else $error("clear without rise");

   // the normal closed level in rising mode stays quiet
   property p_low_no_clear;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && st_q.mode == ARC_RISE && !pin_lvl && !lvl_q) |=> !alarm_clear;
   endproperty
   a_low_no_clear: assert property (p_low_no_clear) else $error("clear while low");

   // general purpose mode never clears
   property p_gpio_never;
      @(posedge clock) disable iff (!rst_b)
      (clk_en && st_q.mode == ARC_GPIO) |=> !alarm_clear;
   endproperty
   a_gpio_never: assert property (p_gpio_never) else $error("clear in gpio mode");

   // no pulse may start on an edge where the block was frozen
   property p_needs_enable;
      @(posedge clock) disable iff (!rst_b)
      $rose(alarm_clear) |-> $past(clk_en);
   endproperty
   a_needs_enable: assert property (p_needs_enable) else $error("clear while frozen");

   // frozen block keeps both outputs as they were
   property p_freeze;
      @(posedge clock) disable iff (!rst_b)
      !clk_en |=> ($stable(alarm_clear) && $stable(gpio_level));
   endproperty
   a_freeze: assert property (p_freeze) else $error("output moved while frozen");

   // mode register follows the configuration one enabled edge later
   property p_mode_tracks;
      @(posedge clock) disable iff (!rst_b)
      clk_en |=> st_q.mode == decode_cfg($past(alarm_reset_config));
   endproperty
   a_mode_tracks: assert property (p_mode_tracks) else $error("mode not loaded");

   // a pulse lasts one enabled cycle; a freeze may stretch it
   property p_one_pulse;
      @(posedge clock) disable iff (!rst_b)
      ($rose(alarm_clear) && clk_en) |-> s_clear_pulse;
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("clear not one cycle");

   property p_gpio_follows;
      @(posedge clock) disable iff (!rst_b)
      clk_en |=> gpio_level == $past(pin_lvl);
   endproperty
   a_gpio_follows: assert property (p_gpio_follows) else $error("gpio level stale");
endmodule : arc_alarm_reset
`default_nettype wire

/* File: verif/arc_host_model.sv */
// host switch model driving the alarm reset pin
`timescale 1ns/1ps
`default_nettype none
module arc_host_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic want,
   output logic pin
);
   // contact settles a clock after the request; open (high) in reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) pin <= 1'b1;
      else pin <= want;
   end
endmodule : arc_host_model
`default_nettype wire

/* File: verif/arc_alarm_reset_tb.sv */
// self-checking bench for the alarm reset edge clear block
`include "arc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module arc_alarm_reset_tb;
   import arc_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic want = 1'b1;
   logic pin;
   logic [`ARC_CFG_W-1:0] cfg = `ARC_CFG_RST;
   logic alarm_clear;
   logic gpio_level;
   logic [3:0] c;
   int n_errors = 0;
   int total_checks = 0;
   always #25 clock = ~clock;
   arc_host_model u_arc_host_model (.clock(clock), .rst_b(rst_b), .want(want), .pin(pin));
   arc_alarm_reset u_arc_alarm_reset (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
      .alarm_reset_input(pin), .alarm_reset_config(cfg), .alarm_clear(alarm_clear),
      .gpio_level(gpio_level));
   // one compare for pulse counts and pin levels alike
   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   // window of ten cycles covers the three-cycle answer plus the model delay
   task automatic step(input logic lvl, output logic [3:0] cnt);
      cnt = 4'h0;
      @(posedge clock);
      want <= lvl;
      repeat (10) begin
         @(posedge clock);
         #1;
         if (alarm_clear === 1'b1) cnt++;
      end
      check({3'h0, gpio_level}, {3'h0, lvl});
   endtask : step
   task automatic set_mode(input logic [`ARC_CFG_W-1:0] v);
      @(posedge clock);
      cfg <= v;
      repeat (3) @(posedge clock);
   endtask : set_mode
   task automatic t_fall;
      set_mode(`ARC_CFG_FALL);
      step(1'b1, c); check(c, 4'h0);
      step(1'b0, c); check(c, 4'h1);
      step(1'b1, c); check(c, 4'h0);
      step(1'b0, c); check(c, 4'h1);
   endtask : t_fall
   // pin is low already, as the rising mode expects
   task automatic t_rise;
      set_mode(`ARC_CFG_RISE);
      step(1'b0, c); check(c, 4'h0);
      step(1'b1, c); check(c, 4'h1);
      step(1'b0, c); check(c, 4'h0);
      step(1'b1, c); check(c, 4'h1);
      step(1'b0, c); check(c, 4'h0);
   endtask : t_rise
   // both the default code and the unused code zero
   task automatic t_gpio;
      set_mode(`ARC_CFG_GPIO);
      step(1'b1, c); check(c, 4'h0);
      step(1'b0, c); check(c, 4'h0);
      set_mode(2'h0);
      step(1'b1, c); check(c, 4'h0);
      step(1'b0, c); check(c, 4'h0);
   endtask : t_gpio
   // freeze across a fall, then release: the fall is judged only afterwards
   task automatic t_hold;
      set_mode(`ARC_CFG_FALL);
      step(1'b1, c); check(c, 4'h0);
      @(posedge clock);
      clk_en <= 1'b0;
      want <= 1'b0;
      c = 4'h0;
      repeat (10) begin
         @(posedge clock);
         #1;
         if (alarm_clear === 1'b1) c++;
      end
      check(c, 4'h0);
      check({3'h0, gpio_level}, 4'h1);
      @(posedge clock);
      clk_en <= 1'b1;
      c = 4'h0;
      repeat (10) begin
         @(posedge clock);
         #1;
         if (alarm_clear === 1'b1) c++;
      end
      check(c, 4'h1);
      check({3'h0, gpio_level}, 4'h0);
   endtask : t_hold
   task automatic complete_run;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      t_fall;
      t_rise;
      t_gpio;
      t_hold;
      complete_run;
   end
   // run needs about 200 cycles; allow many more
   initial begin
      #(50 * 3000);
      n_errors++;
      complete_run;
   end
endmodule : arc_alarm_reset_tb
`default_nettype wire
